// file: include/deea_pkg.sv
`default_nettype none
package deea_pkg;
  // Array geometry
  localparam int DEEA_WORDS = 256;              // Number of 16-bit words held
  localparam int DEEA_IDX_W = 8;                // Word index width
  localparam int DEEA_DATA_W = 16;              // Word width
  localparam int DEEA_ADDR_W = 24;              // Effective address width
  localparam int DEEA_UPPER_W = 8;              // Upper address part width
  localparam int DEEA_LOWER_W = 16;             // Lower address part width
  // Values after reset
  localparam logic [15:0] DEEA_ERASED = 16'hffff;    // Value of an erased word
  localparam logic [7:0] DEEA_UPPER_RST = 8'h00;     // Upper address after reset
  localparam logic [15:0] DEEA_LOWER_RST = 16'h0000; // Lower address after reset
  // Operation timing in cycles per word
  localparam logic [7:0] DEEA_WORD_CYCLES = 8'h04;   // Cycles spent on each word
  // Operation codes requested by software
  typedef enum logic [2:0] {
    DEEA_OP_NONE = 3'h0,
    DEEA_OP_WRITE1 = 3'h1,
    DEEA_OP_ERASE1 = 3'h2,
    DEEA_OP_ERASE4 = 3'h3,
    DEEA_OP_ERASE8 = 3'h4,
    DEEA_OP_BULK = 3'h5
  } deea_op_t;
  // Controller states, Gray coded along idle, run, done
  typedef enum logic [1:0] {
    DEEA_IDLE = 2'b00,
    DEEA_RUN = 2'b01,
    DEEA_DONE = 2'b11
  } deea_state_t;
endpackage
`default_nettype wire

// file: logic/deea_top.sv
`default_nettype none
// Operation
// - Core reaches array only by table operations
// - Sixteen-bit words; high-word operations ignored
// - Erase one, four or eight words
// - Bulk erase clears the whole array
// - Program one word, read one word
// - Last table write address captured, 8+16
// - Address LSb and upper MSb read zero
module deea_top
  import deea_pkg::*;
#(
  parameter int WORDS = DEEA_WORDS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tableWriteLow,
  input wire logic table_write_high_word,
  input wire logic tableReadLow,
  input wire logic table_read_high_word,
  input wire logic [23:0] tableAddr,
  input wire logic [15:0] tableWrData,
  input wire logic [2:0] opCode,
  input wire logic opStart,
  output logic [15:0] tableRdData,
  output logic tableRdValid,
  output logic [7:0] nv_address_upper,
  output logic [15:0] nv_address_lower,
  output logic busy,
  output logic opDone
);
  deea_state_t state_r, state_nxt;      // Controller state
  logic [7:0] upper_r;                   // Captured upper address part
  logic [15:0] lower_r;                  // Captured lower address part
  logic [15:0] latch_r;                  // Data held by the last table write
  logic [2:0] op_r;                      // Operation in progress
  logic [8:0] left_r, left_nxt;          // Words still to process
  logic [7:0] idx_r, idx_nxt;            // Word under work
  logic [7:0] tick_r, tick_nxt;          // Cycles spent on current word
  logic [15:0] rd_r;                     // Read data register
  logic rdv_r;                           // Read valid register
  logic busy_r;                          // Busy register
  logic done_r;                          // Completion pulse register
  logic [15:0] wordQ [WORDS];            // Stored words

  // Decode of requests
  // A table write counts only on the low-word strobe and only while busy is low (idle or done);
  // a write during busy would move the target under a running operation
  wire logic wrTake = tableWriteLow & ~busy_r; // Only low-word path acts
  // Reads are served at any time; while busy their data is not promised
  wire logic rdTake = tableReadLow; // High-word read ignored
  // Starts are taken only from idle, so run and done cycles refuse them
  wire logic goTake = opStart & (state_r == DEEA_IDLE);
  // Word index of a read: even byte address with bit 0 dropped
  wire logic [7:0] rdIdx = tableAddr[8:1];
  // Words beyond the first, per operation code
  wire logic [2:0] cnt = (opCode == DEEA_OP_ERASE4) ? 3'h3 :
                         (opCode == DEEA_OP_ERASE8) ? 3'h7 : 3'h0;
  // Bulk erase walks the whole array from word 0
  wire logic isBulk = (opCode == DEEA_OP_BULK);
  // Codes outside the list are ignored and leave the block idle
  wire logic validOp = (opCode >= DEEA_OP_WRITE1) && (opCode <= DEEA_OP_BULK);
  // Last cycle spent on the current word
  wire logic wordEnd = (state_r == DEEA_RUN) && (tick_r == DEEA_WORD_CYCLES - 8'h01);
  // Program rather than erase for the word strobes
  wire logic isWrite = (op_r == DEEA_OP_WRITE1);
  // Word index of the captured address
  wire logic [7:0] baseIdx = lower_r[8:1];
  // A multi-word erase starts on its own four- or eight-word boundary,
  // so an odd target still clears a whole aligned group
  wire logic [7:0] alignIdx = (cnt == 3'h7) ? {baseIdx[7:3], 3'h0} :
                              (cnt == 3'h3) ? {baseIdx[7:2], 2'h0} : baseIdx;

  // Next state of the sequencer
  // Each word takes a fixed number of cycles; the word strobe fires on the
  // last of them, and the count of words left decides when to stop
  always_comb begin
    // Hold everything unless a branch below moves it
    state_nxt = state_r;
    left_nxt = left_r;
    idx_nxt = idx_r;
    tick_nxt = tick_r;
    case (state_r)
      // Waiting for a start
      DEEA_IDLE: begin
        tick_nxt = 8'h00;
        // Accept only a known operation code
        if (goTake && validOp) begin
          state_nxt = DEEA_RUN;
          // First word: row start for erase, word 0 for bulk
          idx_nxt = isBulk ? 8'h00 : alignIdx;
          // Words still to do after the first one
          left_nxt = isBulk ? 9'(WORDS - 1) : {6'h00, cnt};
        end
      end
      // Working through the words
      DEEA_RUN: begin
        tick_nxt = tick_r + 8'h01;
        // End of the current word
        if (wordEnd) begin
          tick_nxt = 8'h00;
          // Last word finished
          if (left_r == 9'h000) begin
            state_nxt = DEEA_DONE;
          end else begin
            // Step on to the next word
            left_nxt = left_r - 9'h001;
            idx_nxt = idx_r + 8'h01;
          end
        end
      end
      // One cycle that shows completion and refuses a new start
      DEEA_DONE: begin
        state_nxt = DEEA_IDLE;
      end
      // Unused code falls back to idle
      default: begin
        state_nxt = DEEA_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= DEEA_IDLE;
      left_r <= 9'h000;
      idx_r <= 8'h00;
      tick_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
      idx_r <= idx_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Operation latch and status
  // Busy follows the next state so that it rises with the first run cycle
  // and falls in the same cycle in which the done pulse appears
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= DEEA_OP_NONE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (goTake && validOp) begin
        op_r <= opCode;
      end
      busy_r <= (state_nxt == DEEA_RUN);
      done_r <= (state_r == DEEA_RUN) && (state_nxt == DEEA_DONE);
    end
  end

  // Capture of the last table write address and data
  // Bit 0 and the top address bit are forced low, as only even addresses
  // inside user space can name a word
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      upper_r <= DEEA_UPPER_RST;
      lower_r <= DEEA_LOWER_RST;
      latch_r <= DEEA_ERASED;
    end else if (wrTake) begin
      upper_r <= {1'b0, tableAddr[22:16]};
      lower_r <= {tableAddr[15:1], 1'b0};
      latch_r <= tableWrData;
    end
  end

  // Storage array, one word module per location
  for (genvar g = 0; g < WORDS; g++) begin : gWord
    wire logic hit = wordEnd && (idx_r == 8'(g));
    deea_word #(.WIDTH(DEEA_DATA_W)) uWord (
      .clock(clock),
      .sys_rst(sys_rst),
      .eraseEn(hit && !isWrite),
      .progEn(hit && isWrite),
      .progData(latch_r),
      .wordQ(wordQ[g])
    );
  end

  // Read path; data while busy carries no guarantee
  // The valid pulse follows every low-word read strobe by one cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_r <= 16'h0000;
      rdv_r <= 1'b0;
    end else begin
      rdv_r <= rdTake;
      if (rdTake) begin
        rd_r <= wordQ[rdIdx];
      end
    end
  end

  // Outputs straight from flip-flops
  assign tableRdData = rd_r;
  assign tableRdValid = rdv_r;
  assign nv_address_upper = upper_r;
  assign nv_address_lower = lower_r;
  assign busy = busy_r;
  assign opDone = done_r;
endmodule
`default_nettype wire

// file: logic/deea_word.sv
`default_nettype none
// One storage word with erase and program controls
module deea_word
  import deea_pkg::*;
#(
  parameter int WIDTH = DEEA_DATA_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic eraseEn,
  input wire logic progEn,
  input wire logic [WIDTH-1:0] progData,
  output logic [WIDTH-1:0] wordQ
);
  // Erase wins over program when both are raised
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wordQ <= DEEA_ERASED;
    end else if (eraseEn) begin
      wordQ <= DEEA_ERASED;
    end else if (progEn) begin
      wordQ <= progData;
    end
  end
endmodule
`default_nettype wire

// file: verif/deea_asserts.sv
`default_nettype none
// Port-level checker for the EEPROM access block
module deea_chk
  import deea_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tableWriteLow,
  input wire logic tableReadLow,
  input wire logic [23:0] tableAddr,
  input wire logic [2:0] opCode,
  input wire logic opStart,
  input wire logic tableRdValid,
  input wire logic [7:0] nv_address_upper,
  input wire logic [15:0] nv_address_lower,
  input wire logic busy,
  input wire logic opDone
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Start pulse that the controller accepts
  wire logic go = opStart && !busy && !opDone;
  property p_rdv; tableReadLow |=> tableRdValid; endproperty
  a_rdv: assert property (p_rdv) else $error("no read valid");
  property p_rdq; !tableReadLow |=> !tableRdValid; endproperty
  a_rdq: assert property (p_rdq) else $error("stray read valid");
  property p_cap;
    tableWriteLow && !busy |=>
      {nv_address_upper, nv_address_lower} == ($past(tableAddr) & 24'h7ffffe);
  endproperty
  a_cap: assert property (p_cap) else $error("address capture");
  property p_hold;
    !tableWriteLow |=> $stable({nv_address_upper, nv_address_lower});
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_w1; go && opCode == 3'h1 |=> busy [*4] ##1 (opDone && !busy); endproperty
  a_w1: assert property (p_w1) else $error("write timing");
  property p_e4;
    go && opCode == 3'h3 |=> busy [*8] ##8 busy ##1 (opDone && !busy);
  endproperty
  a_e4: assert property (p_e4) else $error("erase4 timing");
  property p_e8; go && opCode == 3'h4 |=> ##32 (opDone && !busy); endproperty
  a_e8: assert property (p_e8) else $error("erase8 timing");
  property p_fall; $fell(busy) |-> opDone; endproperty
  a_fall: assert property (p_fall) else $error("busy end");
endmodule
bind deea_top deea_chk i_chk (.*);
`default_nettype wire

// file: verif/deea_core.sv
`default_nettype none
// Processor core model issuing table operations
module deea_core
  import deea_pkg::*;
(
  input wire logic clock,
  input wire logic opDone,
  output logic tableWriteLow,
  output logic table_write_high_word,
  output logic tableReadLow,
  output logic table_read_high_word,
  output logic [23:0] tableAddr,
  output logic [15:0] tableWrData,
  output logic [2:0] opCode,
  output logic opStart
);
  timeunit 1ns;
  timeprecision 1ns;
  // All strobes idle at start
  initial {tableWriteLow, table_write_high_word, tableReadLow, table_read_high_word,
    tableAddr, tableWrData, opCode, opStart} = '0;
  // Table write, low or high word; lines scrambled after release
  task automatic tw(input logic hi, input logic [23:0] a, input logic [15:0] d);
    @(posedge clock);
    {tableWriteLow, table_write_high_word, tableAddr, tableWrData} <= {!hi, hi, a, d};
    @(posedge clock);
    {tableWriteLow, table_write_high_word, tableAddr, tableWrData} <= {2'b00, ~a, ~d};
  endtask
  // Table read, low or high word
  task automatic tr(input logic hi, input logic [23:0] a);
    @(posedge clock);
    {tableReadLow, table_read_high_word, tableAddr} <= {!hi, hi, a};
    @(posedge clock);
    {tableReadLow, table_read_high_word, tableAddr} <= {2'b00, ~a};
  endtask
  // Start an operation and wait for its end before any read
  task automatic op(input logic [2:0] c);
    @(posedge clock);
    {opStart, opCode} <= {1'b1, c};
    @(posedge clock);
    opStart <= 1'b0;
    // A lost completion is left to the bench watchdog
    @(posedge clock iff opDone === 1'b1);
  endtask
endmodule
`default_nettype wire

// file: verif/deea_top_tb.sv
`default_nettype none
// Self-checking bench: driver notes expected reads, monitor compares
module deea_top_tb
  import deea_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic tableWriteLow, table_write_high_word, tableReadLow, table_read_high_word, opStart;
  logic [23:0] tableAddr;
  logic [15:0] tableWrData, tableRdData, nv_address_lower;
  logic [2:0] opCode;
  logic [7:0] nv_address_upper;
  logic tableRdValid, busy, opDone;
  logic [15:0] mem [256]; // Expected array contents
  logic [15:0] expQ [$]; // Expected read results
  int mismatches = 0;
  int nChecks = 0;
  deea_top i_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .tableWriteLow(tableWriteLow),
    .table_write_high_word(table_write_high_word),
    .tableReadLow(tableReadLow),
    .table_read_high_word(table_read_high_word),
    .tableAddr(tableAddr),
    .tableWrData(tableWrData),
    .opCode(opCode),
    .opStart(opStart),
    .tableRdData(tableRdData),
    .tableRdValid(tableRdValid),
    .nv_address_upper(nv_address_upper),
    .nv_address_lower(nv_address_lower),
    .busy(busy),
    .opDone(opDone)
  );
  deea_core i_core (
    .clock(clock),
    .opDone(opDone),
    .tableWriteLow(tableWriteLow),
    .table_write_high_word(table_write_high_word),
    .tableReadLow(tableReadLow),
    .table_read_high_word(table_read_high_word),
    .tableAddr(tableAddr),
    .tableWrData(tableWrData),
    .opCode(opCode),
    .opStart(opStart)
  );
  // 10 MHz clock
  always #50 clock = ~clock;
  task automatic close_out();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Byte address of word i with random noise above and in bit 0
  function automatic logic [23:0] ad(input int i);
    return {8'($urandom), 7'($urandom), i[7:0], 1'($urandom)};
  endfunction
  task automatic rd(input int i);
    expQ.push_back(mem[i]);
    i_core.tr(1'b0, ad(i));
  endtask
  task automatic er(input logic [2:0] c, input int i, input int n);
    int b;
    b = i & ~(n - 1);
    i_core.tw(1'b0, ad(i), 16'($urandom));
    i_core.op(c);
    for (int k = 0; k < n; k++) mem[b + k] = DEEA_ERASED;
    for (int k = 0; k < 8; k++) rd(k);
  endtask
  // Monitor: every read result takes the oldest note
  always @(posedge clock) begin
    if (tableRdValid === 1'b1) begin
      if (expQ.size() == 0) chk(24'h1, 24'h0);
      else chk({8'h00, tableRdData}, {8'h00, expQ.pop_front()});
    end
  end
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
  initial begin
    logic [23:0] a;
    logic [15:0] d;
    void'($urandom(32'h4438936f));
    foreach (mem[i]) mem[i] = DEEA_ERASED;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({nv_address_upper, nv_address_lower}, 24'h0);
    rd(9);
    for (int j = 0; j < 4; j++) begin
      a = ad(j);
      i_core.tw(1'b0, a, 16'($urandom));
      @(posedge clock);
      chk({nv_address_upper, nv_address_lower}, a & 24'h7ffffe);
      i_core.tw(1'b1, ~a, 16'($urandom));
      @(posedge clock);
      chk({nv_address_upper, nv_address_lower}, a & 24'h7ffffe);
    end
    $display("address capture test done");
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      i_core.tw(1'b0, ad(i), d);
      i_core.op(3'h1);
      mem[i] = d;
    end
    er(3'h3, 5, 4);
    er(3'h2, 1, 1);
    er(3'h4, 3, 8);
    i_core.tr(1'b1, ad(0));
    $display("word and erase test done");
    er(3'h5, 200, 256);
    rd(200);
    repeat (4) @(posedge clock);
    $display("bulk erase test done");
    close_out();
  end
endmodule
`default_nettype wire
